// [src/ecm_pkg.sv]
// package for the expander configuration and transition mask block
// assumes a serial bus engine outside that presents decoded byte reads and writes
//
// Function
// - config register at 0x04; bit 0 low is shutdown, high is normal operation
// - config bit 7 enables transition detection, independent of shutdown bit
// - mask register at 0x06; write bits 6..0 set masks of ports 30..24
// - mask read returns status flag in bit 7; flag clears after read
// - after reset: shutdown, detection off, all masks cleared
// - bits without function read back as zero
package ecm_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [6:0] ECM_ADDR_CONFIG = 7'h04;
  localparam logic [6:0] ECM_ADDR_MASK = 7'h06;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int ECM_CFG_RUN_BIT = 0;
  localparam int ECM_CFG_DET_BIT = 7;
  localparam int ECM_MASK_FLAG_BIT = 7;
  localparam int ECM_NPORTS = 7;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic ECM_RUN_RST = 1'h0;
  localparam logic ECM_DET_RST = 1'h0;
  localparam logic [6:0] ECM_MASK_RST = 7'h00;
  localparam logic ECM_FLAG_RST = 1'h0;
  localparam logic [6:0] ECM_PORT_RST = 7'h00;
  localparam logic [7:0] ECM_RDATA_RST = 8'h00;

  // one register access from the serial engine
  typedef struct packed {
    logic wr;
    logic rd;
    logic [6:0] addr;
    logic [7:0] wdata;
  } ecm_req_t;

endpackage

// [src/ecm_regs.sv]
// register bank: configuration and transition mask, with transition detector
// assumes req is a one-cycle strobe from the bus engine, ports synchronous to core_clk
`timescale 1ns/1ns
module ecm_regs (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire ecm_pkg::ecm_req_t req,
  input wire logic [6:0] port_in,
  output logic [7:0] rdata,
  output logic run_mode,
  output logic detect_en,
  output logic [6:0] port_mask,
  output logic int_flag
);

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  logic wr_cfg;
  logic wr_mask;
  logic rd_cfg;
  logic rd_mask;

  // true when a strobe of one kind lands on one register address
  function automatic logic hit(input logic strobe, input logic [6:0] addr, input logic [6:0] target);
    hit = strobe && (addr == target);
  endfunction

  // unmapped addresses decode to nothing, so writes there fall away
  always_comb begin
    wr_cfg = hit(req.wr, req.addr, ecm_pkg::ECM_ADDR_CONFIG);
    wr_mask = hit(req.wr, req.addr, ecm_pkg::ECM_ADDR_MASK);
    rd_cfg = hit(req.rd, req.addr, ecm_pkg::ECM_ADDR_CONFIG);
    rd_mask = hit(req.rd, req.addr, ecm_pkg::ECM_ADDR_MASK);
  end

  // ----------------------------------------------------------------
  // configuration register
  // ----------------------------------------------------------------
  logic run_q;
  logic run_d;
  logic det_q;
  logic det_d;

  // bits 6..1 are not stored at all, which keeps their read value at zero
  always_comb begin
    run_d = run_q;
    det_d = det_q;
    if (wr_cfg) begin
      run_d = req.wdata[ecm_pkg::ECM_CFG_RUN_BIT];
      det_d = req.wdata[ecm_pkg::ECM_CFG_DET_BIT];
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      run_q <= ecm_pkg::ECM_RUN_RST;
      det_q <= ecm_pkg::ECM_DET_RST;
    end else begin
      run_q <= run_d;
      det_q <= det_d;
    end
  end

  // ----------------------------------------------------------------
  // transition mask register
  // ----------------------------------------------------------------
  logic [6:0] mask_q;
  logic [6:0] mask_d;

  // bit 7 of a write is dropped: the status flag is not writable
  always_comb begin
    mask_d = mask_q;
    if (wr_mask) begin
      mask_d = req.wdata[ecm_pkg::ECM_NPORTS-1:0];
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mask_q <= ecm_pkg::ECM_MASK_RST;
    end else begin
      mask_q <= mask_d;
    end
  end

  // ----------------------------------------------------------------
  // transition detector and status flag
  // ----------------------------------------------------------------
  logic [6:0] prev_q;
  logic [6:0] prev_d;
  logic flag_q;
  logic flag_d;
  logic change;

  // history restarts at zero; harmless since detection is off after reset
  always_comb begin
    prev_d = port_in;
    // only enabled ports whose mask bit is set can raise the flag
    change = det_q && (|((port_in ^ prev_q) & mask_q));
    // a new change in the read cycle wins, so the event is not lost
    flag_d = change ? 1'b1 : (rd_mask ? 1'b0 : flag_q);
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_q <= ecm_pkg::ECM_PORT_RST;
      flag_q <= ecm_pkg::ECM_FLAG_RST;
    end else begin
      prev_q <= prev_d;
      flag_q <= flag_d;
    end
  end

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;

  // read data stands one cycle and is zero otherwise, so stale bytes never linger
  always_comb begin
    rdata_d = 8'h00;
    if (rd_cfg) begin
      rdata_d = {det_q, 6'h00, run_q};
    end else if (rd_mask) begin
      // flag value before its clear is what the host sees
      rdata_d = {flag_q, mask_q};
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= ecm_pkg::ECM_RDATA_RST;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign rdata = rdata_q;
  assign run_mode = run_q;
  assign detect_en = det_q;
  assign port_mask = mask_q;
  assign int_flag = flag_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_cfg_write;
    req.wr && req.addr == ecm_pkg::ECM_ADDR_CONFIG;
  endsequence

  sequence s_mask_write;
    req.wr && req.addr == ecm_pkg::ECM_ADDR_MASK;
  endsequence

  sequence s_cfg_read;
    req.rd && req.addr == ecm_pkg::ECM_ADDR_CONFIG;
  endsequence

  sequence s_mask_read;
    req.rd && req.addr == ecm_pkg::ECM_ADDR_MASK;
  endsequence

  sequence s_idle_bus;
    !req.rd && !req.wr;
  endsequence

  chk_cfg_read_bits: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_cfg_read |=> rdata[7] == $past(detect_en) && rdata[0] == $past(run_mode))
    else $error("config read bits wrong");
  chk_cfg_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_idle_bus |=> $stable(run_mode) && $stable(detect_en)) else $error("config changed without write");
  chk_mask_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_mask_read |=> $stable(port_mask)) else $error("mask changed by read");
  chk_mask_flag_kept: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_mask_write && !change |=> int_flag == $past(int_flag)) else $error("write touched flag");
  chk_rdata_idle: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_idle_bus |=> rdata == 8'h00) else $error("read data not zero when idle");
  chk_flag_set_wins: assert property (@(posedge core_clk) disable iff (!rst_n)
    change && rd_mask |=> int_flag) else $error("read clear beat new change");
  chk_flag_quiet: assert property (@(posedge core_clk) disable iff (!rst_n)
    !change && !int_flag |=> !int_flag) else $error("flag set without change");
  chk_flag_sticky: assert property (@(posedge core_clk) disable iff (!rst_n)
    int_flag && !rd_mask |=> int_flag) else $error("flag dropped without read");

  chk_cfg_run_write: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_cfg_write |=> run_mode == $past(req.wdata[0])) else $error("run bit not written");
  chk_cfg_det_write: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_cfg_write |=> detect_en == $past(req.wdata[7])) else $error("detect bit not written");
  chk_mask_write: assert property (@(posedge core_clk) disable iff (!rst_n)
    req.wr && req.addr == ecm_pkg::ECM_ADDR_MASK |=> port_mask == $past(req.wdata[6:0]))
    else $error("mask not written");
  chk_mask_read_data: assert property (@(posedge core_clk) disable iff (!rst_n)
    rd_mask |=> rdata == {$past(int_flag), $past(port_mask)}) else $error("mask read wrong");
  chk_flag_clear: assert property (@(posedge core_clk) disable iff (!rst_n)
    rd_mask && !change |=> !int_flag) else $error("flag not cleared by read");
  chk_cfg_zero_bits: assert property (@(posedge core_clk) disable iff (!rst_n)
    req.rd && req.addr == ecm_pkg::ECM_ADDR_CONFIG |=> rdata[6:1] == 6'h00)
    else $error("unused config bits not zero");
  chk_flag_set_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
    change |=> int_flag ##1 (int_flag || $past(rd_mask))) else $error("flag not set on change");
  chk_flag_no_cause: assert property (@(posedge core_clk) disable iff (!rst_n)
    !det_q && !int_flag |=> !int_flag) else $error("flag set while detection off");
  chk_reset_vals: assert property (@(posedge core_clk)
    $rose(rst_n) |-> !run_mode && !detect_en && port_mask == 7'h00) else $error("bad reset values");

endmodule // ecm_regs

// [verification/ecm_host.sv]
// host model: issues single-byte register accesses as one-cycle strobes
// assumes the bench owns clock and reset
`timescale 1ns/1ns
module ecm_host (
  input wire logic core_clk,
  output ecm_pkg::ecm_req_t req
);
  initial req = '0;
  task automatic acc(input logic w, input logic [6:0] a, input logic [7:0] d);
    @(posedge core_clk);
    req <= '{wr: w, rd: !w, addr: a, wdata: (w && a == 7'h04) ? (d & 8'hbf) : d};
    @(posedge core_clk);
    req <= '0;
  endtask
endmodule // ecm_host

// [verification/expander_config_and_transition_mask_bench.sv]
// bench: random register traffic and port activity against a reference model
// assumes ecm_regs and the ecm_host model
`timescale 1ns/1ns
module expander_config_and_transition_mask_bench;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [6:0] port_in = 7'h00;
  logic [7:0] rdata;
  logic run_mode, detect_en, int_flag;
  logic [6:0] port_mask;
  ecm_pkg::ecm_req_t req;
  int miscompares = 0, total_checks = 0, seed = 62;
  int run = 0, det = 0, mask = 0, flag = 0, pv = 0, op;
  logic [7:0] d, e;
  logic [6:0] p;
  always #5 core_clk = ~core_clk;
  ecm_host ecm_host_inst (.core_clk(core_clk), .req(req));
  ecm_regs ecm_regs_inst (.core_clk(core_clk), .rst_n(rst_n), .req(req), .port_in(port_in), .rdata(rdata),
    .run_mode(run_mode), .detect_en(detect_en), .port_mask(port_mask), .int_flag(int_flag));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge core_clk);
    miscompares++;
    stop_test();
  end
  initial begin
    repeat (12) @(posedge core_clk);
    rst_n <= 1'b1;
    @(negedge core_clk);
    chk({int_flag, port_mask}, 8'h00);
    chk({6'h00, detect_en, run_mode}, 8'h00);
    repeat (300) begin
      p = 7'($random(seed));
      d = 8'($random(seed));
      op = {$random(seed)} % 6;
      @(posedge core_clk);
      port_in <= p;
      if (det != 0 && ((p ^ pv) & mask) != 0) flag = 1;
      pv = p;
      // let the change land in the flag before any read can race it
      repeat (3) @(posedge core_clk);
      e = 8'h00;
      case (op)
        0: begin run = d[0]; det = d[7]; end
        1: mask = d[6:0];
        2: e = {det[0], 6'h00, run[0]};
        3: begin e = {flag[0], mask[6:0]}; flag = 0; end
        default: ;
      endcase
      ecm_host_inst.acc(op < 2 || op == 5, op == 4 ? 7'h05 : op == 5 ? 7'h07 : op[0] ? 7'h06 : 7'h04, d);
      @(negedge core_clk);
      chk(rdata, e);
      chk({int_flag, port_mask}, {flag[0], mask[6:0]});
      chk({6'h00, detect_en, run_mode}, {6'h00, det[0], run[0]});
    end
    stop_test();
  end
endmodule // expander_config_and_transition_mask_bench
